// [aalo_core.v]
// accumulator datapath: add with carry, and, or, invert, zero, inc, dec,
// decimal adjust, with carry and auxiliary carry flags
// assumes the decoder presents one opcode strobe per instruction and,
// for immediate forms, a later strobe with the second program byte
`include "aalo_map.vh"

module aalo_core #(
  parameter AW = 6
) (
  // clock and reset
  input wire i_sys_clk,
  input wire i_reset_n,
  // instruction strobes from the decoder
  input wire i_op_valid,
  input wire [7:0] i_op_code,
  input wire i_imm_valid,
  input wire [7:0] i_imm_data,
  input wire i_bank_sel,
  // data memory write port from the core
  input wire i_ram_we,
  input wire [AW-1:0] i_ram_waddr,
  input wire [7:0] i_ram_wdata,
  // state outputs
  output reg [7:0] o_acc,
  output reg o_carry,
  output reg o_aux_carry,
  output reg o_busy,
  output reg o_need_imm,
  output reg o_done
);
  // sequencer states
  localparam [1:0] S_IDLE = 2'b00;
  localparam [1:0] S_PTR = 2'b01;
  localparam [1:0] S_OPND = 2'b10;
  localparam [1:0] S_IMM = 2'b11;

  reg [1:0] state_reg; // sequencer state
  reg [1:0] state_next;
  reg [7:0] code_reg; // held opcode
  reg [7:0] code_next;
  reg [AW-1:0] raddr_reg; // memory read address
  reg [AW-1:0] raddr_next;
  wire [7:0] ram_rdata; // registered read data
  reg [7:0] acc_next;
  reg c_next;
  reg ac_next;
  reg exec; // result is committed this cycle
  reg use_opnd; // commit takes a fetched or immediate operand
  reg [7:0] exec_code; // opcode being executed
  reg [7:0] operand; // second operand
  reg [8:0] sum; // add result with carry out
  reg [8:0] t1; // decimal adjust low step
  reg [8:0] t2; // decimal adjust high step
  reg hi_fix; // high nibble needs correction
  wire [AW-1:0] bank_base; // base of working registers

  // =====================================================================
  // helpers
  // 8-bit add with carry in, carry out in bit 8
  function [8:0] aalo_add8;
    input [7:0] a;
    input [7:0] b;
    input cin;
    begin
      aalo_add8 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    end
  endfunction

  // carry out of the low nibble
  function aalo_nib_carry;
    input [7:0] a;
    input [7:0] b;
    input cin;
    reg [4:0] s;
    begin
      s = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      aalo_nib_carry = s[4];
    end
  endfunction

  // register-form opcode of a given high nibble
  function aalo_is_reg;
    input [7:0] code;
    begin
      aalo_is_reg = code[`AALO_REG_FORM_BIT];
    end
  endfunction

  // indirect-form opcode: bit3 clear, bits 2..1 clear
  function aalo_is_ind;
    input [7:0] code;
    begin
      aalo_is_ind = (code[3:1] == 3'b000);
    end
  endfunction

  assign bank_base = i_bank_sel ? `AALO_BANK1_BASE : `AALO_BANK0_BASE;

  // =====================================================================
  // operand memory
  aalo_ram #(
    .AW(AW),
    .DW(8)
  ) u_ram (
    .i_sys_clk(i_sys_clk),
    .i_we(i_ram_we),
    .i_waddr(i_ram_waddr),
    .i_wdata(i_ram_wdata),
    // next address, so the byte already stands in the following state
    .i_raddr(raddr_next),
    .o_rdata(ram_rdata)
  );

  // =====================================================================
  // sequencer: fetch operand, then commit
  always @* begin
    state_next = state_reg;
    code_next = code_reg;
    raddr_next = raddr_reg;
    exec = 1'b0;
    exec_code = code_reg;
    operand = ram_rdata;
    use_opnd = 1'b0;
    case (state_reg)
      S_IDLE: begin
        exec_code = i_op_code;
        if (i_op_valid) begin
          code_next = i_op_code;
          if (i_op_code[7:4] == `AALO_HI_ADD_WITH_CARRY_OP || i_op_code[7:4] == `AALO_HI_AND ||
              i_op_code[7:4] == `AALO_HI_OR) begin
            if (aalo_is_reg(i_op_code)) begin
              // read the working register itself
              raddr_next = bank_base + {{(AW-3){1'b0}}, i_op_code[2:0]};
              state_next = S_OPND;
            end else if (aalo_is_ind(i_op_code)) begin
              // read r0 or r1 as pointer
              raddr_next = bank_base + {{(AW-1){1'b0}}, i_op_code[0]};
              state_next = S_PTR;
            end else if (i_op_code[3:0] == `AALO_LO_IMM &&
                         i_op_code[7:4] != `AALO_HI_ADD_WITH_CARRY_OP) begin
              state_next = S_IMM;
            end else begin
              exec = 1'b1; // decimal adjust and unused codes of these groups
            end
          end else begin
            exec = 1'b1; // implied forms commit at once
          end
        end
      end
      S_PTR: begin
        // low six bits of the pointer address the operand
        raddr_next = ram_rdata[`AALO_PTR_MSB:0];
        state_next = S_OPND;
      end
      S_OPND: begin
        exec = 1'b1;
        use_opnd = 1'b1;
        state_next = S_IDLE;
      end
      S_IMM: begin
        operand = i_imm_data;
        if (i_imm_valid) begin
          exec = 1'b1; // second byte, committed when its strobe arrives
          use_opnd = 1'b1;
          state_next = S_IDLE;
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  // =====================================================================
  // arithmetic and logic unit
  always @* begin
    acc_next = o_acc;
    c_next = o_carry;
    ac_next = o_aux_carry;
    sum = aalo_add8(o_acc, operand, o_carry);
    t1 = aalo_add8(o_acc, (o_acc[3:0] > `AALO_NIB_MAX || o_aux_carry) ?
                   `AALO_ADJ_LO : 8'h00, 1'b0);
    hi_fix = (t1[7:4] > `AALO_NIB_MAX) || o_carry || t1[8];
    t2 = aalo_add8(t1[7:0], hi_fix ? `AALO_ADJ_HI : 8'h00, 1'b0);
    if (exec) begin
      if (exec_code == `AALO_OP_DECADJ) begin
        // decimal adjust shares the and group's high nibble
        acc_next = t2[7:0];
        c_next = o_carry | t1[8] | t2[8];
      end else if (use_opnd) begin
        // operand forms: memory byte or immediate byte
        case (exec_code[7:4])
          `AALO_HI_ADD_WITH_CARRY_OP: begin
            acc_next = sum[7:0];
            c_next = sum[8];
            ac_next = aalo_nib_carry(o_acc, operand, o_carry);
          end
          `AALO_HI_AND: begin
            acc_next = o_acc & operand;
          end
          `AALO_HI_OR: begin
            acc_next = o_acc | operand;
          end
          default: begin
            acc_next = o_acc; // no operand form of this group
          end
        endcase
      end else begin
        // implied forms; unknown codes leave everything alone
        case (exec_code)
          `AALO_OP_INVERT: acc_next = ~o_acc;
          `AALO_OP_ZERO: acc_next = 8'h00;
          `AALO_OP_DEC: acc_next = o_acc - 8'h01;
          `AALO_OP_INC: acc_next = o_acc + 8'h01;
          default: acc_next = o_acc; // not this block's opcode
        endcase
      end
    end
  end

  // =====================================================================
  // state and output registers
  always @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= S_IDLE;
      code_reg <= 8'h00;
      raddr_reg <= {AW{1'b0}};
      o_acc <= `AALO_ACC_RST;
      o_carry <= 1'b0;
      o_aux_carry <= 1'b0;
      o_busy <= 1'b0;
      o_need_imm <= 1'b0;
      o_done <= 1'b0;
    end else begin
      state_reg <= state_next;
      code_reg <= code_next;
      raddr_reg <= raddr_next;
      o_acc <= acc_next;
      o_carry <= c_next;
      o_aux_carry <= ac_next;
      o_busy <= (state_next != S_IDLE);
      o_need_imm <= (state_next == S_IMM);
      o_done <= exec;
    end
  end
endmodule // aalo_core

// [aalo_map.vh]
// constants of the accumulator arithmetic and logic datapath
// assumes inclusion by aalo_core.v only; aalo_ram.v does not include it
`ifndef AALO_MAP_VH
`define AALO_MAP_VH

// =====================================================================
// opcode fields
`define AALO_HI_ADD_WITH_CARRY_OP 4'h7
`define AALO_HI_AND 4'h5
`define AALO_HI_OR 4'h4
`define AALO_LO_IMM 4'h3
`define AALO_OP_INVERT 8'h37
`define AALO_OP_ZERO 8'h27
`define AALO_OP_DECADJ 8'h57
`define AALO_OP_DEC 8'h07
`define AALO_OP_INC 8'h17
`define AALO_REG_FORM_BIT 3

// =====================================================================
// data constants
`define AALO_NIB_MAX 4'h9
`define AALO_ADJ_LO 8'h06
`define AALO_ADJ_HI 8'h60
`define AALO_PTR_MSB 5
`define AALO_BANK1_BASE 6'h18
`define AALO_BANK0_BASE 6'h00
`define AALO_ACC_RST 8'h00

`endif

// [aalo_ram.v]
// internal data memory, one write port and one registered read port
// assumes a single clock; read data appear one edge after the address
module aalo_ram #(
  parameter AW = 6,
  parameter DW = 8
) (
  // clock
  input wire i_sys_clk,
  // write port
  input wire i_we,
  input wire [AW-1:0] i_waddr,
  input wire [DW-1:0] i_wdata,
  // read port
  input wire [AW-1:0] i_raddr,
  output reg [DW-1:0] o_rdata
);
  // storage array
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // =====================================================================
  // write and registered read
  always @(posedge i_sys_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule // aalo_ram

// [aalo_chk.sv]
// checker: timing and result relations at the accumulator datapath ports
// assumes binding onto aalo_core, one clock, async active-low reset
module aalo_chk (
  // clock and reset
  input wire i_sys_clk,
  input wire i_reset_n,
  // decoder strobes
  input wire i_op_valid,
  input wire [7:0] i_op_code,
  input wire i_imm_valid,
  // observed state
  input wire [7:0] o_acc,
  input wire o_carry,
  input wire o_busy,
  input wire o_need_imm,
  input wire o_done
);
  // =====================================================
  // opcode acceptance and properties
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  wire tk = i_op_valid && !o_busy; // opcode taken at this edge
  a_invert_all: assert property (
    tk && i_op_code == 8'h37 |=> o_done && o_acc == ~$past(o_acc))
    else $error("invert result wrong");
  a_zero_acc: assert property (
    tk && i_op_code == 8'h27 |=> o_done && o_acc == 8'h00)
    else $error("clear result wrong");
  a_inc_wrap: assert property (
    tk && i_op_code == 8'h17 |=> o_acc == $past(o_acc) + 8'h01)
    else $error("increment wrong");
  a_dec_wrap: assert property (
    tk && i_op_code == 8'h07 |=> o_acc == $past(o_acc) - 8'h01)
    else $error("decrement wrong");
  a_reg_two: assert property (
    tk && i_op_code[7:4] == 4'h5 && i_op_code[3] |=> o_busy ##1 o_done)
    else $error("register form timing wrong");
  a_imm_wait: assert property (
    tk && (i_op_code == 8'h53 || i_op_code == 8'h43) |=> o_need_imm && !o_done)
    else $error("immediate not awaited");
  a_imm_done: assert property (
    i_imm_valid && o_need_imm |=> o_done && !o_need_imm)
    else $error("immediate not committed");
  a_adj_carry: assert property (
    tk && i_op_code == 8'h57 && o_carry |=> o_carry)
    else $error("decimal adjust lost carry");
  // decimal adjust is implied: one edge, then idle again
  a_adj_done: assert property (
    tk && i_op_code == 8'h57 |=> o_done && !o_busy)
    else $error("decimal adjust not committed");
  // indirect add: pointer read, operand read, then commit
  a_ind_three: assert property (
    tk && i_op_code[7:4] == 4'h7 && i_op_code[3:1] == 3'b000 |=> o_busy ##1 o_busy ##1 o_done)
    else $error("indirect form timing wrong");
endmodule // aalo_chk

bind aalo_core aalo_chk aalo_chk_inst (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
  .i_op_valid(i_op_valid), .i_op_code(i_op_code), .i_imm_valid(i_imm_valid), .o_acc(o_acc),
  .o_carry(o_carry), .o_busy(o_busy), .o_need_imm(o_need_imm), .o_done(o_done));

// [aalo_tb.sv]
// testbench: drives the accumulator datapath and checks acc and flags
// assumes aalo_core and its bound checker; inputs change on falling edges
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  // =====================================================
  // stimulus and observed signals
  logic i_sys_clk = 1'b0, i_reset_n = 1'b0, i_op_valid = 1'b0, i_imm_valid = 1'b0;
  logic i_bank_sel = 1'b0, i_ram_we = 1'b0;
  logic [7:0] i_op_code = 8'h00, i_imm_data = 8'h00, i_ram_wdata = 8'h00;
  logic [5:0] i_ram_waddr = 6'h00;
  wire [7:0] o_acc;
  wire o_carry, o_aux_carry, o_busy, o_need_imm, o_done;
  wire [9:0] st = {o_aux_carry, o_carry, o_acc}; // flags and accumulator as compared
  integer failures = 0, checks = 0;
  always #10 i_sys_clk = ~i_sys_clk;
  aalo_core aalo_core_inst (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
    .i_op_valid(i_op_valid), .i_op_code(i_op_code), .i_imm_valid(i_imm_valid),
    .i_imm_data(i_imm_data), .i_bank_sel(i_bank_sel), .i_ram_we(i_ram_we),
    .i_ram_waddr(i_ram_waddr), .i_ram_wdata(i_ram_wdata), .o_acc(o_acc), .o_carry(o_carry),
    .o_aux_carry(o_aux_carry), .o_busy(o_busy), .o_need_imm(o_need_imm), .o_done(o_done));
  // =====================================================
  // shared tasks
  task test_done;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // compare {aux carry, carry, accumulator}
  task chk(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t state %h want %h", $time, got, exp);
    end
  endtask
  // one write into data memory
  task wr(input logic [5:0] a, input logic [7:0] d);
    i_ram_we = 1'b1;
    i_ram_waddr = a;
    i_ram_wdata = d;
    @(negedge i_sys_clk);
    i_ram_we = 1'b0;
    @(negedge i_sys_clk); // strobe rests a cycle before the next write
  endtask
  // issue an opcode, immediate byte if needed, wait for done
  task op(input logic [7:0] c, input logic [7:0] d);
    integer n;
    i_op_valid = 1'b1;
    i_op_code = c;
    @(negedge i_sys_clk);
    i_op_valid = 1'b0;
    if (c == 8'h53 || c == 8'h43) begin
      i_imm_valid = 1'b1;
      i_imm_data = d;
      @(negedge i_sys_clk);
      i_imm_valid = 1'b0;
    end
    n = 0;
    while (o_done !== 1'b1 && n < 8) begin
      @(negedge i_sys_clk);
      n++;
    end
    if (o_done !== 1'b1) begin
      failures++;
      $display("BAD %0t no commit for opcode %h", $time, c);
      test_done;
    end else begin
      @(negedge i_sys_clk); // strobe rests a cycle before the next opcode
    end
  endtask
  // load a value by clear then or immediate
  task ld(input logic [7:0] v);
    op(8'h27, 8'h00);
    op(8'h43, v);
  endtask
  // =====================================================
  // scenarios
  task s_add_with_carry_op;
    wr(6'h01, 8'h8F);
    ld(8'h99);
    op(8'h79, 8'h00);
    chk(st, 10'h328);
    op(8'h79, 8'h00);
    chk(st, 10'h2B8);
    i_bank_sel = 1'b1;
    wr(6'h19, 8'h01);
    ld(8'h10);
    op(8'h79, 8'h00);
    chk(st, 10'h011);
    i_bank_sel = 1'b0;
  endtask
  task s_indir;
    wr(6'h00, 8'hC5);
    wr(6'h05, 8'h3C);
    ld(8'h0F);
    op(8'h70, 8'h00);
    chk(st, 10'h24B);
    op(8'h50, 8'h00);
    chk(st, 10'h208);
    op(8'h49, 8'h00);
    chk(st, 10'h28F);
    op(8'h5D, 8'h00);
    chk(st, 10'h20C);
    op(8'h53, 8'h04);
    chk(st, 10'h204);
  endtask
  task s_impl;
    op(8'h27, 8'h00);
    chk(st, 10'h200);
    op(8'h07, 8'h00);
    chk(st, 10'h2FF);
    op(8'h17, 8'h00);
    chk(st, 10'h200);
    op(8'h37, 8'h00);
    chk(st, 10'h2FF);
  endtask
  task s_dadj;
    ld(8'h12);
    op(8'h57, 8'h00);
    chk(st, 10'h218);
    wr(6'h02, 8'h00);
    ld(8'h9A);
    op(8'h7A, 8'h00);
    op(8'h57, 8'h00);
    chk(st, 10'h100);
    op(8'h57, 8'h00);
    chk(st, 10'h160);
  endtask
  // =====================================================
  // main sequence
  initial begin
    repeat (4) @(negedge i_sys_clk);
    i_reset_n = 1'b1;
    s_add_with_carry_op;
    s_indir;
    s_impl;
    s_dadj;
    test_done;
  end
endmodule // testbench
